//--- verilog/bmrc_device.sv
`timescale 1ns/1ps
// Notes on behaviour
// - strap low at start: recovery, no navigation
// - recovery: internal oscillator, configuration straps ignored
// - host opens uart with two 0x55 bytes
// - host waits 2 ms after training
// - recovery mode accepts external flash programming
// - host holds restart low at least 10 ms
// - restart input only, pulled up, high runs
// - restart clears the backup real-time clock
// - host uses restart only for recovery; bmrc_host also drives a plain restart on restart_req
// - no clock kept: take aided time each start
// - host marks edge with time for hot start
// - clock-based power save ignores host time aiding
// - external slow reference 32.768 kHz, always running
module bmrc_device #(
  parameter int unsigned BIT_CYC = bmrc_pkg::BIT_CYC,
  parameter int unsigned RESTART_CYC = bmrc_pkg::RESTART_CYC,
  parameter int unsigned SLOW_TICKS = bmrc_pkg::SLOW_REF_HZ,
  parameter int unsigned CFG_W = bmrc_pkg::CFG_W,
  parameter logic [CFG_W-1:0] CFG_DEFAULT = '0
) (
  input wire logic ref_clk,
  input wire logic rst,
  bmrc_if.dev link,
  input wire logic [CFG_W-1:0] cfg_strap,
  input wire logic psm_rtc_mode,
  output logic in_restart,
  output logic osc_internal,
  output logic comm_ready,
  output logic nav_enable,
  output logic front_amp_on,
  output logic [CFG_W-1:0] cfg_applied,
  output logic flash_wr_valid,
  output logic [7:0] flash_wr_data,
  output logic rtc_running,
  output logic [bmrc_pkg::TIME_W-1:0] time_seconds,
  output logic warm_start_ok,
  output logic hot_start_ok
);
  typedef enum logic [2:0] {D_RESTART, D_START, D_TRAIN, D_RECOVER, D_NAV} bmrc_dstate_e;
  typedef struct packed {
    bmrc_dstate_e st;
    logic [1:0] strap_sy;
    logic [1:0] restart_sy;
    logic [1:0] rxd_sy;
    logic [1:0] slow_sy;
    logic [1:0] mark_sy;
    logic [CFG_W-1:0] cfg_sy1;
    logic [CFG_W-1:0] cfg_sy2;
    logic slow_last;
    logic mark_last;
    logic [31:0] low_cnt;
    logic [3:0] settle;
    logic rx_busy;
    logic [31:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_shift;
    logic [1:0] train_cnt;
    logic wr_valid;
    logic [7:0] wr_data;
    logic [CFG_W-1:0] cfg;
    logic [31:0] slow_cnt;
    logic [bmrc_pkg::TIME_W-1:0] time_s;
    logic rtc_run;
    logic warm_ok;
    logic hot_ok;
    logic mark_pend;
  } bmrc_dstate_s;

  bmrc_dstate_s state_reg;
  bmrc_dstate_s state_next;
  logic restart_low;
  logic rx_done;
  logic slow_edge;
  logic mark_edge;

  always_comb
  begin
    state_next = state_reg;
    rx_done = 1'h0;
    restart_low = ~state_reg.restart_sy[1];
    slow_edge = state_reg.slow_sy[1] & ~state_reg.slow_last;
    mark_edge = state_reg.mark_sy[1] & ~state_reg.mark_last;
    state_next.wr_valid = 1'h0;
    if (rst)
    begin
      state_next = '0;
      state_next.st = D_START;
      state_next.strap_sy = '1;
      state_next.restart_sy = '1;
      state_next.rxd_sy = '1;
      state_next.cfg = CFG_DEFAULT;
    end
    else
    begin
      // pins from the host, except time_load and time_value, cross into ref_clk through two flops
      state_next.strap_sy = {state_reg.strap_sy[0], link.boot_recovery_strap_n};
      state_next.restart_sy = {state_reg.restart_sy[0], link.restart_n};
      state_next.rxd_sy = {state_reg.rxd_sy[0], link.host_txd};
      state_next.slow_sy = {state_reg.slow_sy[0], link.slow_ref};
      state_next.mark_sy = {state_reg.mark_sy[0], link.edge_mark};
      state_next.cfg_sy1 = cfg_strap;
      state_next.cfg_sy2 = state_reg.cfg_sy1;
      state_next.slow_last = state_reg.slow_sy[1];
      state_next.mark_last = state_reg.mark_sy[1];
      // uart receiver, sampled mid-bit; stays armed in every state
      if (!state_reg.rx_busy)
      begin
        if (!state_reg.rxd_sy[1])
        begin
          state_next.rx_busy = 1'h1;
          state_next.rx_cnt = 32'(BIT_CYC / 2);
          state_next.rx_bit = '0;
        end
      end
      else if (state_reg.rx_cnt != 32'h0)
        state_next.rx_cnt = state_reg.rx_cnt - 32'h1;
      else
      begin
        state_next.rx_cnt = 32'(BIT_CYC - 1);
        state_next.rx_bit = state_reg.rx_bit + 4'h1;
        if (state_reg.rx_bit == 4'h0)
        begin
          // glitch, not a start bit
          if (state_reg.rxd_sy[1])
            state_next.rx_busy = 1'h0;
        end
        else if (state_reg.rx_bit < bmrc_pkg::UART_STOP_IDX)
          state_next.rx_shift = {state_reg.rxd_sy[1], state_reg.rx_shift[7:1]};
        else
        begin
          state_next.rx_busy = 1'h0;
          rx_done = state_reg.rxd_sy[1];
        end
      end
      // slow reference advances the clock once it holds a time
      if (slow_edge && state_reg.rtc_run)
      begin
        if (state_reg.slow_cnt == 32'(SLOW_TICKS - 1))
        begin
          state_next.slow_cnt = '0;
          state_next.time_s = state_reg.time_s + {{(bmrc_pkg::TIME_W - 1){1'b0}}, 1'b1};
        end
        else
          state_next.slow_cnt = state_reg.slow_cnt + 32'h1;
      end
      // aided time only when no clock is held and power save does not rely on it
      if (state_reg.st == D_NAV && link.time_load && !state_reg.rtc_run
          && !psm_rtc_mode)
      begin
        state_next.time_s = link.time_value;
        state_next.slow_cnt = '0;
        state_next.rtc_run = 1'h1;
        state_next.warm_ok = 1'h1;
        state_next.hot_ok = state_reg.mark_pend;
        state_next.mark_pend = mark_edge;
      end
      else if (mark_edge)
        state_next.mark_pend = 1'h1;
      case (state_reg.st)
        D_RESTART:
        begin
          if (!restart_low)
          begin
            state_next.st = D_START;
            state_next.settle = '0;
          end
        end
        D_START:
        begin
          // let the strap synchroniser fill before sampling
          state_next.settle = state_reg.settle + 4'h1;
          if (state_reg.settle == bmrc_pkg::SETTLE_CYC)
          begin
            if (!state_reg.strap_sy[1])
            begin
              state_next.st = D_TRAIN;
              state_next.train_cnt = '0;
              state_next.cfg = CFG_DEFAULT;
            end
            else
            begin
              state_next.st = D_NAV;
              state_next.cfg = state_reg.cfg_sy2;
            end
          end
        end
        D_TRAIN:
        begin
          // any other byte restarts the count
          if (rx_done)
          begin
            if (state_reg.rx_shift != bmrc_pkg::TRAIN_BYTE)
              state_next.train_cnt = '0;
            else if (state_reg.train_cnt == bmrc_pkg::TRAIN_COUNT - 2'h1)
              state_next.st = D_RECOVER;
            else
              state_next.train_cnt = state_reg.train_cnt + 2'h1;
          end
        end
        D_RECOVER:
        begin
          // relies on the host gap; bytes go straight to the flash writer
          if (rx_done)
          begin
            state_next.wr_valid = 1'h1;
            state_next.wr_data = state_reg.rx_shift;
          end
        end
        D_NAV:
        begin
        end
        default:
          state_next.st = D_START;
      endcase
      // restart filter: shorter lows are ignored
      if (restart_low)
      begin
        if (state_reg.low_cnt < 32'(RESTART_CYC))
          state_next.low_cnt = state_reg.low_cnt + 32'h1;
      end
      else
        state_next.low_cnt = '0;
      if (restart_low && state_reg.low_cnt == 32'(RESTART_CYC))
      begin
        state_next.st = D_RESTART;
        state_next.wr_valid = 1'h0;
        state_next.rx_busy = 1'h0;
        state_next.rtc_run = 1'h0;
        state_next.time_s = '0;
        state_next.slow_cnt = '0;
        state_next.warm_ok = 1'h0;
        state_next.hot_ok = 1'h0;
        state_next.mark_pend = 1'h0;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    state_reg <= state_next;
  end

  assign in_restart = state_reg.st == D_RESTART;
  assign osc_internal = state_reg.st == D_TRAIN || state_reg.st == D_RECOVER;
  assign comm_ready = state_reg.st == D_RECOVER;
  assign nav_enable = state_reg.st == D_NAV;
  assign front_amp_on = state_reg.st == D_NAV;
  assign cfg_applied = state_reg.cfg;
  assign flash_wr_valid = state_reg.wr_valid;
  assign flash_wr_data = state_reg.wr_data;
  assign rtc_running = state_reg.rtc_run;
  assign time_seconds = state_reg.time_s;
  assign warm_start_ok = state_reg.warm_ok;
  assign hot_start_ok = state_reg.hot_ok;
endmodule // bmrc_device

//--- verilog/bmrc_pkg.sv
package bmrc_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CLK_KHZ = CLK_HZ / 1000;
  localparam int unsigned BAUD = 9600;
  localparam int unsigned BIT_CYC = CLK_HZ / BAUD;
  localparam int unsigned RESTART_MIN_MS = 10;
  localparam int unsigned RESTART_CYC = RESTART_MIN_MS * CLK_KHZ;
  localparam int unsigned TRAIN_GAP_MS = 2;
  localparam int unsigned GAP_CYC = TRAIN_GAP_MS * CLK_KHZ;
  // 32.768 kHz slow reference
  localparam int unsigned SLOW_REF_HZ = 32768;
  localparam int unsigned SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_REF_HZ);
  localparam logic [7:0] TRAIN_BYTE = 8'h55;
  localparam logic [1:0] TRAIN_COUNT = 2'h2;
  // uart frame: index 0 start, 1..8 data, 9 stop
  localparam logic [3:0] UART_STOP_IDX = 4'h9;
  localparam logic [3:0] SETTLE_CYC = 4'h4;
  localparam logic [31:0] STRAP_HOLD_CYC = 32'h10;
  localparam logic [3:0] MARK_LEAD = 4'h8;
  localparam int unsigned CFG_W = 4;
  localparam int unsigned TIME_W = 32;
endpackage

//--- verilog/bmrc_if.sv
`timescale 1ns/1ps
interface bmrc_if;
  logic boot_recovery_strap_n_o;
  logic boot_recovery_strap_n_oe_n;
  logic restart_n_o;
  logic restart_n_oe_n;
  logic boot_recovery_strap_n;
  logic restart_n;
  logic host_txd;
  logic slow_ref;
  logic edge_mark;
  logic time_load;
  logic [bmrc_pkg::TIME_W-1:0] time_value;

  // both pins have pull-ups on the device side
  assign boot_recovery_strap_n = boot_recovery_strap_n_oe_n ? 1'h1 : boot_recovery_strap_n_o;
  assign restart_n = restart_n_oe_n ? 1'h1 : restart_n_o;

  modport host (
    output boot_recovery_strap_n_o,
    output boot_recovery_strap_n_oe_n,
    output restart_n_o,
    output restart_n_oe_n,
    output host_txd,
    output slow_ref,
    output edge_mark,
    output time_load,
    output time_value
  );

  modport dev (
    input boot_recovery_strap_n,
    input restart_n,
    input host_txd,
    input slow_ref,
    input edge_mark,
    input time_load,
    input time_value
  );
endinterface

//--- verilog/bmrc_host.sv
`timescale 1ns/1ps
module bmrc_host #(
  parameter int unsigned BIT_CYC = bmrc_pkg::BIT_CYC,
  parameter int unsigned RESTART_CYC = bmrc_pkg::RESTART_CYC,
  parameter int unsigned GAP_CYC = bmrc_pkg::GAP_CYC,
  parameter int unsigned SLOW_HALF_CYC = bmrc_pkg::SLOW_HALF_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  bmrc_if.host link,
  input wire logic restart_req,
  input wire logic recovery_req,
  output logic busy,
  output logic link_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  input wire logic time_req,
  input wire logic [bmrc_pkg::TIME_W-1:0] time_in,
  output logic time_ready
);
  typedef enum logic [2:0] {H_IDLE, H_RESET, H_HOLD, H_TRAIN, H_GAP, H_READY} bmrc_hstate_e;
  typedef struct packed {
    bmrc_hstate_e st;
    logic recov;
    logic [31:0] cnt;
    logic tx_busy;
    logic [31:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [9:0] tx_sh;
    logic [1:0] sent;
    logic time_busy;
    logic [3:0] mark_cnt;
    logic mark;
    logic load;
    logic [bmrc_pkg::TIME_W-1:0] tval;
    logic [31:0] slow_cnt;
    logic slow;
  } bmrc_hstate_s;

  bmrc_hstate_s state_reg;
  bmrc_hstate_s state_next;
  logic tx_start;
  logic [7:0] tx_byte;
  logic can_restart;

  assign can_restart = (state_reg.st == H_IDLE || state_reg.st == H_READY) && !state_reg.tx_busy;

  always_comb
  begin
    state_next = state_reg;
    tx_start = 1'h0;
    tx_byte = tx_data;
    state_next.load = 1'h0;
    if (rst)
    begin
      state_next = '0;
      state_next.st = H_IDLE;
      state_next.tx_sh = '1;
    end
    else
    begin
      // free-running slow reference, never stopped by restart
      if (state_reg.slow_cnt == 32'(SLOW_HALF_CYC - 1))
      begin
        state_next.slow_cnt = '0;
        state_next.slow = ~state_reg.slow;
      end
      else
        state_next.slow_cnt = state_reg.slow_cnt + 32'h1;
      // restart only on an explicit request, never held as a power switch
      if (can_restart && (restart_req || recovery_req))
      begin
        state_next.st = H_RESET;
        state_next.recov = recovery_req;
        state_next.cnt = '0;
      end
      else
      begin
        case (state_reg.st)
          H_IDLE:
          begin
          end
          H_RESET:
          begin
            // margin covers the device synchroniser
            state_next.cnt = state_reg.cnt + 32'h1;
            if (state_reg.cnt == 32'(RESTART_CYC) + bmrc_pkg::STRAP_HOLD_CYC - 32'h1)
            begin
              state_next.st = H_HOLD;
              state_next.cnt = '0;
            end
          end
          H_HOLD:
          begin
            state_next.cnt = state_reg.cnt + 32'h1;
            if (state_reg.cnt == bmrc_pkg::STRAP_HOLD_CYC - 32'h1)
            begin
              state_next.st = state_reg.recov ? H_TRAIN : H_IDLE;
              state_next.sent = '0;
            end
          end
          H_TRAIN:
          begin
            if (!state_reg.tx_busy)
            begin
              if (state_reg.sent == bmrc_pkg::TRAIN_COUNT)
              begin
                state_next.st = H_GAP;
                state_next.cnt = '0;
              end
              else
              begin
                tx_start = 1'h1;
                tx_byte = bmrc_pkg::TRAIN_BYTE;
                state_next.sent = state_reg.sent + 2'h1;
              end
            end
          end
          H_GAP:
          begin
            state_next.cnt = state_reg.cnt + 32'h1;
            if (state_reg.cnt == 32'(GAP_CYC - 1))
              state_next.st = H_READY;
          end
          H_READY:
            tx_start = tx_valid && !state_reg.tx_busy;
          default:
            state_next.st = H_IDLE;
        endcase
      end
      // uart transmitter, lsb first, one stop bit
      if (tx_start)
      begin
        state_next.tx_busy = 1'h1;
        state_next.tx_sh = {1'h1, tx_byte, 1'h0};
        state_next.tx_cnt = 32'(BIT_CYC - 1);
        state_next.tx_bit = '0;
      end
      else if (state_reg.tx_busy)
      begin
        if (state_reg.tx_cnt != 32'h0)
          state_next.tx_cnt = state_reg.tx_cnt - 32'h1;
        else
        begin
          state_next.tx_cnt = 32'(BIT_CYC - 1);
          state_next.tx_sh = {1'h1, state_reg.tx_sh[9:1]};
          state_next.tx_bit = state_reg.tx_bit + 4'h1;
          if (state_reg.tx_bit == bmrc_pkg::UART_STOP_IDX)
            state_next.tx_busy = 1'h0;
        end
      end
      // mark edge leads the time load so the device has caught it first
      if (time_ready && time_req)
      begin
        state_next.time_busy = 1'h1;
        state_next.mark = 1'h1;
        state_next.mark_cnt = '0;
        state_next.tval = time_in;
      end
      else if (state_reg.time_busy)
      begin
        state_next.mark_cnt = state_reg.mark_cnt + 4'h1;
        if (state_reg.mark_cnt == bmrc_pkg::MARK_LEAD - 4'h1)
        begin
          state_next.mark = 1'h0;
          state_next.load = 1'h1;
          state_next.time_busy = 1'h0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    state_reg <= state_next;
  end

  assign busy = !(state_reg.st == H_IDLE || state_reg.st == H_READY);
  assign link_ready = state_reg.st == H_READY;
  assign tx_ready = link_ready && !state_reg.tx_busy;
  assign time_ready = state_reg.st == H_IDLE && !state_reg.time_busy;
  assign link.restart_n_o = 1'h0;
  assign link.restart_n_oe_n = state_reg.st != H_RESET;
  assign link.boot_recovery_strap_n_o = 1'h0;
  assign link.boot_recovery_strap_n_oe_n =
    !(state_reg.recov && (state_reg.st == H_RESET || state_reg.st == H_HOLD));
  assign link.host_txd = state_reg.tx_sh[0];
  assign link.slow_ref = state_reg.slow;
  assign link.edge_mark = state_reg.mark;
  assign link.time_load = state_reg.load;
  assign link.time_value = state_reg.tval;
endmodule // bmrc_host

//--- tb/bmrc_monitor.sv
`timescale 1ns/1ps
module bmrc_monitor #(
  parameter int unsigned BIT_CYC = 16,
  parameter int unsigned RESTART_CYC = 40,
  parameter int unsigned SLOW_HALF_CYC = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic boot_recovery_strap_n,
  input wire logic restart_n,
  input wire logic host_txd,
  input wire logic slow_ref,
  input wire logic edge_mark,
  input wire logic time_load,
  input wire logic [bmrc_pkg::TIME_W-1:0] time_value
);
  localparam int BIT_M1 = BIT_CYC - 1;
  localparam int HALF = SLOW_HALF_CYC;
  // one cycle of slack for where the count starts
  localparam int LOW_MIN = RESTART_CYC + 15;
  logic [15:0] low_cnt_reg;
  logic [15:0] low_cnt_next;
  always_comb low_cnt_next = restart_n ? 16'h0 : low_cnt_reg + 16'h1;
  always_ff @(posedge ref_clk) low_cnt_reg <= rst ? 16'h0 : low_cnt_next;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  restart_hold_a: assert property ($rose(restart_n) |-> low_cnt_reg >= LOW_MIN)
    else $error("restart pulse too short");
  strap_past_restart_a: assert property
    ($rose(restart_n) && !boot_recovery_strap_n |-> !boot_recovery_strap_n [*8])
    else $error("strap released too early");
  strap_with_restart_a: assert property
    ($fell(boot_recovery_strap_n) |-> $fell(restart_n))
    else $error("strap pulled outside restart");
  start_bit_len_a: assert property ($fell(host_txd) |-> (!host_txd) throughout (##BIT_M1 1'b1))
    else $error("uart low bit shorter than a bit time");
  line_idle_restart_a: assert property (!restart_n |-> host_txd)
    else $error("uart active during restart");
  mark_lead_a: assert property ($rose(edge_mark) |-> edge_mark [*8] ##1 (time_load && !edge_mark))
    else $error("mark not followed by time load");
  load_pulse_a: assert property (time_load |=> !time_load)
    else $error("time load longer than one cycle");
  value_hold_a: assert property (edge_mark && $past(edge_mark) |-> $stable(time_value))
    else $error("time value moved during mark");
  slow_rate_a: assert property ($changed(slow_ref) |-> ##HALF $changed(slow_ref))
    else $error("slow reference rate wrong");
  restart_c: cover property ($rose(restart_n));
  recovery_c: cover property ($rose(restart_n) && !boot_recovery_strap_n);
  load_c: cover property (time_load);
  frame_c: cover property ($fell(host_txd));
endmodule // bmrc_monitor

//--- tb/bmrc_bench.sv
`timescale 1ns/1ps
module bmrc_bench;
  localparam int BIT = 16;
  localparam int RC = 40;
  localparam int GAP = 50;
  typedef struct packed {logic [7:0] data; logic [7:0] exp;} bmrc_row_s;
  localparam bmrc_row_s ROWS [5] = '{'{8'ha5, 8'ha5}, '{8'h00, 8'h00}, '{8'hff, 8'hff},
    '{8'h55, 8'h55}, '{8'h3c, 8'h3c}};
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic restart_req = 1'b0, recovery_req = 1'b0, tx_valid = 1'b0, time_req = 1'b0;
  logic psm_rtc_mode = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic [31:0] time_in = 32'h0;
  logic [3:0] cfg_strap = 4'h5;
  logic busy, link_ready, tx_ready, time_ready, in_restart, osc_internal, comm_ready;
  logic nav_enable, front_amp_on, flash_wr_valid, rtc_running, warm_start_ok, hot_start_ok;
  logic d2_restart, d2_nav, seen, stp;
  logic [3:0] cfg_applied;
  logic [7:0] flash_wr_data, b;
  logic [31:0] time_seconds;
  int n_mismatch = 0;
  int checks = 0;
  int n;
  bmrc_if bmrc_if_inst ();
  bmrc_if bmrc_if_inst2 ();
  bmrc_host #(.BIT_CYC(BIT), .RESTART_CYC(RC), .GAP_CYC(GAP), .SLOW_HALF_CYC(4)) bmrc_host_inst (
    .ref_clk(ref_clk), .rst(rst), .link(bmrc_if_inst.host), .restart_req(restart_req),
    .recovery_req(recovery_req), .busy(busy), .link_ready(link_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .time_req(time_req), .time_in(time_in),
    .time_ready(time_ready));
  bmrc_device #(.BIT_CYC(BIT), .RESTART_CYC(RC), .SLOW_TICKS(4)) bmrc_device_inst (
    .ref_clk(ref_clk), .rst(rst), .link(bmrc_if_inst.dev), .cfg_strap(cfg_strap),
    .psm_rtc_mode(psm_rtc_mode), .in_restart(in_restart), .osc_internal(osc_internal),
    .comm_ready(comm_ready), .nav_enable(nav_enable), .front_amp_on(front_amp_on),
    .cfg_applied(cfg_applied), .flash_wr_valid(flash_wr_valid), .flash_wr_data(flash_wr_data),
    .rtc_running(rtc_running), .time_seconds(time_seconds), .warm_start_ok(warm_start_ok),
    .hot_start_ok(hot_start_ok));
  // second device faces a bench-driven host that breaks the pulse width on purpose
  bmrc_device #(.BIT_CYC(BIT), .RESTART_CYC(RC), .SLOW_TICKS(4)) bmrc_device_inst2 (
    .ref_clk(ref_clk), .rst(rst), .link(bmrc_if_inst2.dev), .cfg_strap(cfg_strap),
    .psm_rtc_mode(psm_rtc_mode), .in_restart(d2_restart), .osc_internal(), .comm_ready(),
    .nav_enable(d2_nav), .front_amp_on(), .cfg_applied(), .flash_wr_valid(),
    .flash_wr_data(), .rtc_running(), .time_seconds(), .warm_start_ok(), .hot_start_ok());
  bmrc_monitor #(.BIT_CYC(BIT), .RESTART_CYC(RC), .SLOW_HALF_CYC(4)) bmrc_monitor_inst (
    .ref_clk(ref_clk), .rst(rst),
    .boot_recovery_strap_n(bmrc_if_inst.boot_recovery_strap_n),
    .restart_n(bmrc_if_inst.restart_n), .host_txd(bmrc_if_inst.host_txd),
    .slow_ref(bmrc_if_inst.slow_ref), .edge_mark(bmrc_if_inst.edge_mark),
    .time_load(bmrc_if_inst.time_load), .time_value(bmrc_if_inst.time_value));
  always #2.5 ref_clk = ~ref_clk;
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      n_mismatch++;
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  task final_report;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // waits out a host restart, noting whether the device went into restart
  task automatic wait_idle(output logic s);
    int i;
    s = 1'b0;
    for (i = 0; i < 400 && busy !== 1'b0; i++)
    begin
      s = s | (in_restart === 1'b1);
      cyc(1);
    end
    chk("busy_end", 32'h1, {31'h0, i < 400});
  endtask
  task automatic aid(input logic [31:0] t);
    time_in = t;
    time_req = 1'b1;
    cyc(1);
    time_req = 1'b0;
    cyc(12);
  endtask
  task automatic rx_byte(output logic [7:0] d, output logic s);
    int i;
    for (i = 0; i < 800 && bmrc_if_inst.host_txd !== 1'b0; i++) cyc(1);
    cyc(BIT / 2);
    for (i = 0; i < 8; i++)
    begin
      cyc(BIT);
      d[i] = bmrc_if_inst.host_txd;
    end
    cyc(BIT);
    s = bmrc_if_inst.host_txd;
  endtask
  task automatic pulse2(input int k, output logic s);
    s = 1'b0;
    bmrc_if_inst2.restart_n_oe_n = 1'b0;
    repeat (k + 10)
    begin
      if (k == 0)
        bmrc_if_inst2.restart_n_oe_n = 1'b1;
      k = k - 1;
      cyc(1);
      s = s | (d2_restart === 1'b1);
    end
  endtask
  initial
  begin
    #100000;
    n_mismatch++;
    final_report;
  end
  initial
  begin
    bmrc_if_inst2.boot_recovery_strap_n_o = 1'b0;
    bmrc_if_inst2.boot_recovery_strap_n_oe_n = 1'b1;
    bmrc_if_inst2.restart_n_o = 1'b0;
    bmrc_if_inst2.restart_n_oe_n = 1'b1;
    bmrc_if_inst2.host_txd = 1'b1;
    bmrc_if_inst2.slow_ref = 1'b0;
    bmrc_if_inst2.edge_mark = 1'b0;
    bmrc_if_inst2.time_load = 1'b0;
    bmrc_if_inst2.time_value = 32'h0;
    cyc(12);
    rst = 1'b0;
    cyc(1);
    chk("nav_start", 32'h0, {31'h0, nav_enable});
    chk("rtc_start", 32'h0, {31'h0, rtc_running});
    cyc(10);
    chk("nav_on", 32'h1, {31'h0, nav_enable});
    chk("amp_on", 32'h1, {31'h0, front_amp_on});
    chk("osc_ext", 32'h0, {31'h0, osc_internal});
    chk("cfg_nav", 32'h5, {28'h0, cfg_applied});
    aid(32'h1000);
    chk("time_load", 32'h1000, time_seconds);
    chk("warm", 32'h1, {31'h0, warm_start_ok});
    chk("hot", 32'h1, {31'h0, hot_start_ok});
    cyc(40);
    chk("time_tick", 32'h1001, time_seconds);
    aid(32'h2000);
    chk("reload_ignored", 32'h1, {12'h0, time_seconds[31:12]});
    restart_req = 1'b1;
    cyc(1);
    restart_req = 1'b0;
    wait_idle(seen);
    chk("restart_seen", 32'h1, {31'h0, seen});
    chk("rtc_cleared", 32'h0, {31'h0, rtc_running});
    chk("time_cleared", 32'h0, time_seconds);
    chk("hot_cleared", 32'h0, {30'h0, hot_start_ok, warm_start_ok});
    psm_rtc_mode = 1'b1;
    aid(32'h3000);
    chk("psm_no_aid", 32'h0, {31'h0, rtc_running});
    psm_rtc_mode = 1'b0;
    // same start-up, power save off: aiding must now land
    aid(32'h3000);
    chk("aid_restart", 32'h3000, time_seconds);
    chk("rtc_aided", 32'h1, {31'h0, rtc_running});
    recovery_req = 1'b1;
    cyc(1);
    recovery_req = 1'b0;
    chk("time_closed", 32'h0, {31'h0, time_ready});
    rx_byte(b, stp);
    chk("train0", 32'h155, {23'h0, stp, b});
    chk("rec_nav", 32'h0, {30'h0, nav_enable, front_amp_on});
    chk("rec_osc", 32'h1, {31'h0, osc_internal});
    chk("rec_cfg", 32'h0, {28'h0, cfg_applied});
    rx_byte(b, stp);
    chk("train1", 32'h155, {23'h0, stp, b});
    chk("tx_closed", 32'h0, {31'h0, tx_ready});
    for (n = 0; n < 400 && link_ready !== 1'b1; n++) cyc(1);
    chk("gap", 32'h1, {31'h0, n >= GAP && n < 400});
    chk("comm", 32'h1, {31'h0, comm_ready});
    foreach (ROWS[r])
    begin
      for (n = 0; n < 400 && tx_ready !== 1'b1; n++) cyc(1);
      tx_valid = 1'b1;
      tx_data = ROWS[r].data;
      cyc(1);
      tx_valid = 1'b0;
      for (n = 0; n < 400 && flash_wr_valid !== 1'b1; n++) cyc(1);
      chk("flash", {24'h0, ROWS[r].exp}, {24'h0, flash_wr_data});
    end
    pulse2(RC / 2, seen);
    chk("short_low", 32'h0, {31'h0, seen});
    pulse2(RC + 10, seen);
    chk("long_low", 32'h1, {31'h0, seen});
    cyc(10);
    chk("open_strap", 32'h1, {31'h0, d2_nav});
    final_report;
  end
endmodule // bmrc_bench
